// ==== dv/tsf_diode_model.sv ====
`timescale 1ns/100ps
// ****************************************
// remote junction model
// ****************************************
module tsf_diode_model
  import tsf_pkg::*;
(
  input  wire logic [3:0][7:0] temp_set,
  input  wire logic [3:0]      open_set,
  input  wire logic [3:0]      vcc_set,
  input  wire logic [1:0]      conv_channel,
  input  wire logic            conv_busy,
  output tsf_meas_type         meas
);
  // only the junction under conversion gives a reading; others show junk so a stale sample is caught
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      meas.temp[i] = (conv_busy && conv_channel == 2'(i)) ? temp_set[i] : ~temp_set[i];
    end
    meas.junction_open             = open_set;
    meas.junction_anode_input_high = vcc_set;
  end
endmodule : tsf_diode_model

// ==== dv/tsf_status_flags_tb_top.sv ====
`timescale 1ns/100ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin failures++; \
  $display("Error at %0t: got %h expected %h", $time, (got), (exp)); end end
module tsf_status_flags_tb_top;
  import tsf_pkg::*;
  // ****************************************
  // bench signals
  // ****************************************
  localparam int CONV = 20;
  localparam int RC   = 30;
  logic            mclk;
  logic            rst;
  tsf_bus_req_type bus_req;
  logic [7:0]      rdata;
  tsf_meas_type    meas;
  logic [1:0]      conv_channel;
  logic            conv_busy;
  logic            conv_done;
  logic            rcancel_active;
  logic            ch1_overtemp_flag;
  logic            ch4_overtemp_flag;
  logic            overtemp_output;
  logic            irq;
  logic [3:0][7:0] temp_set;
  logic [3:0]      open_set;
  logic [3:0]      vcc_set;
  logic            rca;
  int              failures;
  int              comparisons;
  int              cycles;
  int              len;
  int              n;

  tsf_status_flags #(.CONV_CYCLES(CONV), .RCANCEL_CYCLES(RC)) DUT (
    .mclk(mclk), .rst(rst), .bus_req(bus_req), .rdata(rdata), .meas(meas),
    .conv_channel(conv_channel), .conv_busy(conv_busy), .conv_done(conv_done),
    .rcancel_active(rcancel_active), .ch1_overtemp_flag(ch1_overtemp_flag),
    .ch4_overtemp_flag(ch4_overtemp_flag), .overtemp_output(overtemp_output), .irq(irq));

  tsf_diode_model diodes (
    .temp_set(temp_set), .open_set(open_set), .vcc_set(vcc_set),
    .conv_channel(conv_channel), .conv_busy(conv_busy), .meas(meas));

  // ****************************************
  // tasks
  // ****************************************
  task automatic summarize();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus_req.wr <= 1'b0;
    #1;
  endtask : wr_reg

  // read data stand only in the cycle after the strobe
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus_req.rd <= 1'b0;
    #1;
    `CHK(rdata, exp)
  endtask : chk_rd

  // bounded wait; returns one cycle after the end so flags have landed
  task automatic wait_conv(input logic [1:0] ch);
    int k;
    for (k = 0; k < 400; k++) begin
      @(posedge mclk);
      #1;
      if (conv_done === 1'b1 && conv_channel === ch) break;
    end
    if (k == 400) begin
      failures++;
      $display("Error at %0t: no conversion end", $time);
    end
    @(posedge mclk);
    #1;
  endtask : wait_conv

  task automatic conv_len();
    wait_conv(2'd3);
    len = 0;
    rca = 1'b0;
    for (int k = 0; k < 400; k++) begin
      if (conv_busy === 1'b1 && conv_channel === 2'd0) len++;
      if (rcancel_active === 1'b1) rca = 1'b1;
      if (conv_done === 1'b1 && conv_channel === 2'd0) break;
      @(posedge mclk);
      #1;
    end
  endtask : conv_len

  // ****************************************
  // clock and timeout
  // ****************************************
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      summarize();
    end
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    rst = 1'b1;
    bus_req = '0;
    temp_set = {8'h20, 8'h20, 8'h20, 8'h20};
    open_set = 4'h0;
    vcc_set = 4'h0;
    failures = 0;
    comparisons = 0;
    cycles = 0;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    // first read right at release still sees the spare bits low
    bus_req <= '{addr: TSF_OFF_DIODE_FAULT, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus_req.rd <= 1'b0;
    #1;
    `CHK(rdata, 8'h00)
    chk_rd(TSF_OFF_OVERTEMP_STAT, 8'h00);
    chk_rd(TSF_OFF_DIODE_FAULT, 8'h60);
    chk_rd(TSF_OFF_CH1_LIMIT, TSF_RST_LIMIT);
    chk_rd(8'hff, 8'h00);
    wr_reg(TSF_OFF_OVERTEMP_STAT, 8'hff);
    chk_rd(TSF_OFF_OVERTEMP_STAT, 8'h00);
    // channel 1 over limit, sticky until read, pin held through reads
    wr_reg(TSF_OFF_CH1_LIMIT, 8'h50);
    temp_set[0] <= 8'h51;
    wait_conv(2'd0);
    `CHK(ch1_overtemp_flag, 1'b1)
    chk_rd(TSF_OFF_OVERTEMP_STAT, 8'h01);
    chk_rd(TSF_OFF_OVERTEMP_STAT, 8'h00);
    `CHK(overtemp_output, 1'b1)
    wr_reg(TSF_OFF_CONFIG3, 8'h01);
    `CHK(overtemp_output, 1'b0)
    wr_reg(TSF_OFF_CONFIG3, 8'h00);
    // just inside the hysteresis band the pin stays up
    temp_set[0] <= 8'h4c;
    wait_conv(2'd0);
    `CHK(overtemp_output, 1'b1)
    `CHK(ch1_overtemp_flag, 1'b0)
    temp_set[0] <= 8'h4b;
    wait_conv(2'd0);
    `CHK(overtemp_output, 1'b0)
    // channel 4: equal is not over; mask keeps the pin low
    wr_reg(TSF_OFF_CH4_LIMIT, 8'h40);
    wr_reg(TSF_OFF_CONFIG3, 8'h08);
    temp_set[3] <= 8'h40;
    wait_conv(2'd3);
    `CHK(ch4_overtemp_flag, 1'b0)
    temp_set[3] <= 8'h41;
    wait_conv(2'd3);
    `CHK(ch4_overtemp_flag, 1'b1)
    `CHK(overtemp_output, 1'b0)
    wr_reg(TSF_OFF_CONFIG3, 8'h00);
    `CHK(overtemp_output, 1'b1)
    chk_rd(TSF_OFF_OVERTEMP_STAT, 8'h08);
    // interrupt: masked, raised, cleared
    `CHK(irq, 1'b0)
    wr_reg(TSF_OFF_IRQ_MASK, 8'h08);
    wait_conv(2'd1);
    `CHK(irq, 1'b1)
    wr_reg(TSF_OFF_IRQ_STATUS, 8'h0f);
    `CHK(irq, 1'b0)
    wr_reg(TSF_OFF_IRQ_MASK, 8'h00);
    // faults on three channels; only channel 3 may convert
    open_set <= 4'b0011;
    vcc_set <= 4'b1000;
    chk_rd(TSF_OFF_DIODE_FAULT, 8'h76);
    n = 0;
    repeat (200) begin
      @(posedge mclk);
      #1;
      if (conv_busy === 1'b1 && conv_channel !== 2'd2) n++;
    end
    `CHK(n, 0)
    open_set <= 4'b0000;
    vcc_set <= 4'b0100;
    chk_rd(TSF_OFF_DIODE_FAULT, 8'h68);
    vcc_set <= 4'b0000;
    chk_rd(TSF_OFF_DIODE_FAULT, 8'h60);
    // cancellation lengthens channel 1 only
    conv_len();
    `CHK(len, CONV)
    `CHK(rca, 1'b0)
    wr_reg(TSF_OFF_CONFIG1, 8'h08);
    conv_len();
    `CHK(len, CONV + RC)
    `CHK(rca, 1'b1)
    wait_conv(2'd1);
    repeat (5) @(posedge mclk);
    #1;
    `CHK(rcancel_active, 1'b0)
    summarize();
  end
endmodule : tsf_status_flags_tb_top

// ==== src/tsf_overtemp_chan.sv ====
`timescale 1ns/100ps
module tsf_overtemp_chan
  import tsf_pkg::*;
#(
  parameter int unsigned W    = 8,
  parameter int unsigned HYST = TSF_HYST_DEG
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic         eval,
  input  wire logic [W-1:0] temp,
  input  wire logic [W-1:0] limit,
  output logic              over_cond,
  output logic              over_event
);

  if (W < 2 || HYST >= (1 << W)) begin : g_bad_param
    $error("tsf_overtemp_chan: bad width or hysteresis");
  end

  tsf_chan_state_type s_r;
  tsf_chan_state_type s_nxt;
  logic               above;
  logic               below_hyst;

  // widened by one bit so the hysteresis sum cannot wrap
  assign above      = temp > limit;
  assign below_hyst = ({1'b0, temp} + W'(HYST)) < {1'b0, limit};
  assign over_event = eval & above;
  assign over_cond  = s_r.cond;

  always_comb begin
    s_nxt = s_r;
    if (eval && above) begin
      s_nxt.cond = 1'b1;
    end else if (eval && below_hyst) begin
      s_nxt.cond = 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule : tsf_overtemp_chan

// ==== src/tsf_pkg.sv ====
package tsf_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] TSF_OFF_CONFIG1       = 8'h00;
  localparam logic [7:0] TSF_OFF_CONFIG3       = 8'h01;
  localparam logic [7:0] TSF_OFF_CH1_LIMIT     = 8'h02;
  localparam logic [7:0] TSF_OFF_CH4_LIMIT     = 8'h03;
  localparam logic [7:0] TSF_OFF_OVERTEMP_STAT = 8'h04;
  localparam logic [7:0] TSF_OFF_DIODE_FAULT   = 8'h05;
  localparam logic [7:0] TSF_OFF_IRQ_STATUS    = 8'h06;
  localparam logic [7:0] TSF_OFF_IRQ_MASK      = 8'h07;
  localparam logic [7:0] TSF_OFF_SEQ_STATE     = 8'h08;

  // ****************************************
  // field positions
  // ****************************************
  localparam int TSF_CFG1_RCANCEL_BIT  = 3;
  localparam int TSF_CFG3_MASK_CH1_BIT = 0;
  localparam int TSF_CFG3_MASK_CH4_BIT = 3;
  localparam int TSF_OT_CH1_BIT        = 0;
  localparam int TSF_OT_CH4_BIT        = 3;
  localparam int TSF_DF_LSB            = 1;
  localparam int TSF_DF_SPARE_LO       = 5;
  localparam int TSF_IRQ_OT_CH1        = 0;
  localparam int TSF_IRQ_OT_CH4        = 1;
  localparam int TSF_IRQ_FAULT         = 2;
  localparam int TSF_IRQ_CONV_DONE     = 3;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] TSF_RST_CONFIG   = 8'h00;
  localparam logic [7:0] TSF_RST_LIMIT    = 8'h7f;
  localparam logic [3:0] TSF_RST_IRQ_MASK = 4'h0;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned TSF_CLK_HZ        = 100_000_000;
  localparam int unsigned TSF_CYC_PER_MS    = TSF_CLK_HZ / 1000;
  localparam int unsigned TSF_RCANCEL_MS    = 125;
  localparam int unsigned TSF_RCANCEL_CYC   = TSF_RCANCEL_MS * TSF_CYC_PER_MS;
  localparam int unsigned TSF_CONV_MS       = 50;
  localparam int unsigned TSF_CONV_CYC      = TSF_CONV_MS * TSF_CYC_PER_MS;
  localparam int unsigned TSF_HYST_DEG      = 4;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    TSF_SEQ_PICK = 2'b00,
    TSF_SEQ_CONV = 2'b01
  } tsf_seq_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } tsf_bus_req_type;

  typedef struct packed {
    logic [3:0][7:0] temp;
    logic [3:0]      junction_open;
    logic [3:0]      junction_anode_input_high;
  } tsf_meas_type;

  typedef struct packed {
    tsf_seq_type seq;
    logic [1:0]  ch;
    logic [31:0] cnt;
    logic        rc_on;
    logic [7:0]  cfg1;
    logic [7:0]  cfg3;
    logic [7:0]  lim1;
    logic [7:0]  lim4;
    logic [1:0]  ot_flags;
    logic [3:0]  fault;
    logic        por_done;
    logic [3:0]  irq_st;
    logic [3:0]  irq_mask;
    logic [7:0]  rdata;
  } tsf_state_type;

  typedef struct packed {
    logic cond;
  } tsf_chan_state_type;

endpackage : tsf_pkg

// ==== src/tsf_status_flags.sv ====
`timescale 1ns/100ps
// What this block does
// - set overtemp status bit 3 when channel 4 exceeds its limit
// - set overtemp status bit 0 when channel 1 exceeds its limit
// - fault status bits 6 and 5 read 0 after reset, 1 afterwards
// - fault status bit n set while channel n junction open or anode high
// - resistance cancellation on channel 1 only, while config1 bit 3 set
// - cancellation lengthens the channel 1 conversion by 125 ms
// - overtemp flags clear only on read; read leaves the pin alone
// - overtemp condition removed only below limit minus 4 degrees
// - faulted channels are skipped by the conversion sequence
// - config3 bit 3 keeps channel 4 overtemp off the pin
module tsf_status_flags
  import tsf_pkg::*;
#(
  parameter int unsigned CONV_CYCLES    = TSF_CONV_CYC,
  parameter int unsigned RCANCEL_CYCLES = TSF_RCANCEL_CYC
) (
  input  wire logic            mclk,
  input  wire logic            rst,
  input  wire tsf_bus_req_type bus_req,
  output logic [7:0]           rdata,
  input  wire tsf_meas_type    meas,
  output logic [1:0]           conv_channel,
  output logic                 conv_busy,
  output logic                 conv_done,
  output logic                 rcancel_active,
  output logic                 ch1_overtemp_flag,
  output logic                 ch4_overtemp_flag,
  output logic                 overtemp_output,
  output logic                 irq
);

  if (CONV_CYCLES < 1 || RCANCEL_CYCLES < 1 ||
      CONV_CYCLES + RCANCEL_CYCLES > 32'hffff_ffff - 1) begin : g_bad_param
    $error("tsf_status_flags: conversion counts out of range");
  end

  // ****************************************
  // state
  // ****************************************
  tsf_state_type s_r;
  tsf_state_type s_nxt;

  logic       cond1;
  logic       cond4;
  logic       ev1;
  logic       ev4;
  logic       eval1;
  logic       eval4;
  logic       pick_ok;
  logic [1:0] pick_ch;
  logic [3:0] fault_in;
  logic       wr_hit;
  logic       rd_ot;

  assign fault_in = meas.junction_open | meas.junction_anode_input_high;
  assign wr_hit   = bus_req.wr;
  assign rd_ot    = bus_req.rd && bus_req.addr == TSF_OFF_OVERTEMP_STAT;

  // conversion of a channel finishes when the counter runs out
  assign conv_done = s_r.seq == TSF_SEQ_CONV && s_r.cnt == 32'h0 && !s_r.fault[s_r.ch];
  assign eval1     = conv_done && s_r.ch == 2'h0;
  assign eval4     = conv_done && s_r.ch == 2'h3;

  // ****************************************
  // overtemp comparators
  // ****************************************
  tsf_overtemp_chan #(
    .W    (8),
    .HYST (TSF_HYST_DEG)
  ) u_ot_ch1 (
    .mclk       (mclk),
    .rst        (rst),
    .eval       (eval1),
    .temp       (meas.temp[0]),
    .limit      (s_r.lim1),
    .over_cond  (cond1),
    .over_event (ev1)
  );

  tsf_overtemp_chan #(
    .W    (8),
    .HYST (TSF_HYST_DEG)
  ) u_ot_ch4 (
    .mclk       (mclk),
    .rst        (rst),
    .eval       (eval4),
    .temp       (meas.temp[3]),
    .limit      (s_r.lim4),
    .over_cond  (cond4),
    .over_event (ev4)
  );

  // ****************************************
  // next channel search
  // ****************************************
  always_comb begin
    logic [1:0] idx;
    idx     = 2'h0;
    pick_ok = 1'b0;
    pick_ch = s_r.ch;
    for (int i = 1; i <= 4; i++) begin
      idx = s_r.ch + 2'(i);
      if (!pick_ok && !s_r.fault[idx]) begin
        pick_ok = 1'b1;
        pick_ch = idx;
      end
    end
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [7:0] rd_mux;
    logic [3:0] irq_ev;
    logic [3:0] irq_clr;
    rd_mux  = 8'h00;
    irq_ev  = 4'h0;
    irq_clr = 4'h0;
    s_nxt   = s_r;

    s_nxt.por_done = 1'b1;
    s_nxt.fault    = fault_in;

    // sequencer
    case (s_r.seq)
      TSF_SEQ_PICK: begin
        if (pick_ok) begin
          s_nxt.seq   = TSF_SEQ_CONV;
          s_nxt.ch    = pick_ch;
          s_nxt.rc_on = pick_ch == 2'h0 && s_r.cfg1[TSF_CFG1_RCANCEL_BIT];
          if (pick_ch == 2'h0 && s_r.cfg1[TSF_CFG1_RCANCEL_BIT]) begin
            s_nxt.cnt = 32'(CONV_CYCLES + RCANCEL_CYCLES - 1);
          end else begin
            s_nxt.cnt = 32'(CONV_CYCLES - 1);
          end
        end
      end
      TSF_SEQ_CONV: begin
        // a channel that faults mid-conversion is dropped, not measured
        if (s_r.fault[s_r.ch] || s_r.cnt == 32'h0) begin
          s_nxt.seq   = TSF_SEQ_PICK;
          s_nxt.rc_on = 1'b0;
        end else begin
          s_nxt.cnt = s_r.cnt - 32'h1;
        end
      end
      default: begin
        s_nxt.seq = TSF_SEQ_PICK;
      end
    endcase

    // overtemp flags: read clears, a new event in the same cycle wins
    if (rd_ot) begin
      s_nxt.ot_flags = 2'b00;
    end
    if (ev1) begin
      s_nxt.ot_flags[0] = 1'b1;
    end
    if (ev4) begin
      s_nxt.ot_flags[1] = 1'b1;
    end

    // register writes
    if (wr_hit) begin
      case (bus_req.addr)
        TSF_OFF_CONFIG1:    s_nxt.cfg1 = bus_req.wdata;
        TSF_OFF_CONFIG3:    s_nxt.cfg3 = bus_req.wdata;
        TSF_OFF_CH1_LIMIT:  s_nxt.lim1 = bus_req.wdata;
        TSF_OFF_CH4_LIMIT:  s_nxt.lim4 = bus_req.wdata;
        TSF_OFF_IRQ_STATUS: irq_clr    = bus_req.wdata[3:0];
        TSF_OFF_IRQ_MASK:   s_nxt.irq_mask = bus_req.wdata[3:0];
        default: begin
        end
      endcase
    end

    // interrupt status, write one to clear, set wins
    irq_ev[TSF_IRQ_OT_CH1]    = ev1;
    irq_ev[TSF_IRQ_OT_CH4]    = ev4;
    irq_ev[TSF_IRQ_FAULT]     = |(fault_in & ~s_r.fault);
    irq_ev[TSF_IRQ_CONV_DONE] = conv_done;
    s_nxt.irq_st = (s_r.irq_st & ~irq_clr) | irq_ev;

    // read mux, data valid only in the cycle after the strobe
    case (bus_req.addr)
      TSF_OFF_CONFIG1:       rd_mux = s_r.cfg1;
      TSF_OFF_CONFIG3:       rd_mux = s_r.cfg3;
      TSF_OFF_CH1_LIMIT:     rd_mux = s_r.lim1;
      TSF_OFF_CH4_LIMIT:     rd_mux = s_r.lim4;
      TSF_OFF_OVERTEMP_STAT: begin
        rd_mux[TSF_OT_CH1_BIT] = s_r.ot_flags[0];
        rd_mux[TSF_OT_CH4_BIT] = s_r.ot_flags[1];
      end
      TSF_OFF_DIODE_FAULT: begin
        rd_mux[TSF_DF_LSB +: 4]      = s_r.fault;
        rd_mux[TSF_DF_SPARE_LO +: 2] = {2{s_r.por_done}};
      end
      TSF_OFF_IRQ_STATUS:    rd_mux = {4'h0, s_r.irq_st};
      TSF_OFF_IRQ_MASK:      rd_mux = {4'h0, s_r.irq_mask};
      TSF_OFF_SEQ_STATE:     rd_mux = {3'h0, s_r.rc_on, s_r.seq == TSF_SEQ_CONV, 1'b0, s_r.ch};
      default:               rd_mux = 8'h00;
    endcase
    s_nxt.rdata = bus_req.rd ? rd_mux : 8'h00;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_r          <= '0;
      s_r.seq      <= TSF_SEQ_PICK;
      s_r.ch       <= 2'h3;
      s_r.cfg1     <= TSF_RST_CONFIG;
      s_r.cfg3     <= TSF_RST_CONFIG;
      s_r.lim1     <= TSF_RST_LIMIT;
      s_r.lim4     <= TSF_RST_LIMIT;
      s_r.irq_mask <= TSF_RST_IRQ_MASK;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign rdata             = s_r.rdata;
  assign conv_channel      = s_r.ch;
  assign conv_busy         = s_r.seq == TSF_SEQ_CONV;
  assign rcancel_active    = s_r.seq == TSF_SEQ_CONV && s_r.rc_on;
  assign ch1_overtemp_flag = s_r.ot_flags[0];
  assign ch4_overtemp_flag = s_r.ot_flags[1];
  // pin follows the live condition, so reading the flags never drops it
  assign overtemp_output   = (cond1 && !s_r.cfg3[TSF_CFG3_MASK_CH1_BIT]) ||
                             (cond4 && !s_r.cfg3[TSF_CFG3_MASK_CH4_BIT]);
  assign irq               = |(s_r.irq_st & s_r.irq_mask);

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_conv_start_ch1_rc;
    s_r.seq == TSF_SEQ_PICK && pick_ok && pick_ch == 2'h0 && s_r.cfg1[TSF_CFG1_RCANCEL_BIT];
  endsequence

  // a conversion end in the read cycle may move the pin legitimately, so it is left out here
  sequence s_rd_ot;
    rd_ot && !eval1 && !eval4;
  endsequence

  a_ot_ch4_set: assert property (ev4 |=> ch4_overtemp_flag)
    else $error("channel 4 overtemp flag not set");

  a_ot_ch1_set: assert property (ev1 |=> ch1_overtemp_flag)
    else $error("channel 1 overtemp flag not set");

  a_spare_bits: assert property (
    bus_req.rd && bus_req.addr == TSF_OFF_DIODE_FAULT && !$past(rst) |=> rdata[6:5] == 2'b11)
    else $error("spare fault bits not one after reset");

  a_fault_follow: assert property (##1 s_r.fault == $past(fault_in))
    else $error("diode fault bits do not follow junction state");

  a_rc_only_ch1: assert property (rcancel_active |-> conv_channel == 2'h0)
    else $error("cancellation active off channel 1");

  a_conv_extend: assert property (
    s_conv_start_ch1_rc |=> s_r.cnt == 32'(CONV_CYCLES + RCANCEL_CYCLES - 1) && rcancel_active)
    else $error("channel 1 conversion not lengthened");

  a_ot_read_clear: assert property (
    s_rd_ot |=> ch1_overtemp_flag == 1'b0 && ch4_overtemp_flag == 1'b0
                && overtemp_output == $past(overtemp_output))
    else $error("overtemp read did not clear flags or moved the pin");

  a_hysteresis: assert property (
    cond1 && !(eval1 && ({1'b0, meas.temp[0]} + 9'(TSF_HYST_DEG)) < {1'b0, s_r.lim1}) |=> cond1)
    else $error("channel 1 overtemp removed inside hysteresis");

  a_skip_fault: assert property (
    s_r.seq == TSF_SEQ_PICK && pick_ok |-> !s_r.fault[pick_ch] ##1 conv_busy)
    else $error("faulted channel entered the sequence");

  a_ch4_mask: assert property (
    s_r.cfg3[TSF_CFG3_MASK_CH4_BIT] && (!cond1 || s_r.cfg3[TSF_CFG3_MASK_CH1_BIT]) |-> !overtemp_output)
    else $error("masked channel 4 drove the overtemp pin");

  a_reserved_zero: assert property (
    bus_req.rd && bus_req.addr == TSF_OFF_OVERTEMP_STAT |=> rdata[7:4] == 4'h0 && rdata[2:1] == 2'h0)
    else $error("reserved overtemp status bits not zero");

  a_spare_por: assert property (
    $past(rst) && bus_req.rd && bus_req.addr == TSF_OFF_DIODE_FAULT |=> rdata[6:5] == 2'b00)
    else $error("spare fault bits not zero on the first read after reset");

  a_fault_reserved: assert property (
    bus_req.rd && bus_req.addr == TSF_OFF_DIODE_FAULT |=> rdata[7] == 1'b0 && rdata[0] == 1'b0)
    else $error("reserved fault status bits not zero");

  a_abort_fault: assert property (conv_busy && s_r.fault[s_r.ch] |-> !conv_done ##1 !conv_busy)
    else $error("faulted channel finished its conversion");

  a_all_faulted: assert property (s_r.seq == TSF_SEQ_PICK && !pick_ok |=> !conv_busy)
    else $error("conversion started with every channel faulted");

  sequence s_conv_start_plain;
    s_r.seq == TSF_SEQ_PICK && pick_ok && !(pick_ch == 2'h0 && s_r.cfg1[TSF_CFG1_RCANCEL_BIT]);
  endsequence

  a_conv_base: assert property (s_conv_start_plain |=> s_r.cnt == 32'(CONV_CYCLES - 1) && !rcancel_active)
    else $error("plain conversion has the wrong length");

  a_cnt_step: assert property (
    conv_busy && s_r.cnt != 32'h0 && !s_r.fault[s_r.ch] |=> conv_busy && s_r.cnt == $past(s_r.cnt) - 32'h1)
    else $error("conversion counter skipped a step");

  a_ch1_sticky: assert property (ch1_overtemp_flag && !rd_ot |=> ch1_overtemp_flag)
    else $error("channel 1 overtemp flag dropped without a read");

  a_ch4_sticky: assert property (ch4_overtemp_flag && !rd_ot |=> ch4_overtemp_flag)
    else $error("channel 4 overtemp flag dropped without a read");

  a_ch1_set_cause: assert property ($rose(ch1_overtemp_flag) |-> $past(ev1))
    else $error("channel 1 overtemp flag set without an event");

  a_ch4_set_cause: assert property ($rose(ch4_overtemp_flag) |-> $past(ev4))
    else $error("channel 4 overtemp flag set without an event");

  a_hyst_ch4: assert property (
    cond4 && !(eval4 && ({1'b0, meas.temp[3]} + 9'(TSF_HYST_DEG)) < {1'b0, s_r.lim4}) |=> cond4)
    else $error("channel 4 overtemp removed inside hysteresis");

  a_pin_needs_cond: assert property (!cond1 && !cond4 |-> !overtemp_output)
    else $error("overtemp pin high with no condition");

endmodule : tsf_status_flags
